// >>> design/sid_top.sv
// serial port register front end with prioritized interrupt identification
// assumes host read and write strobes are one-cycle pulses on clk
//
// Contract
// - line status error reports code 110, top
// - reading line status clears that interrupt
// - received data code 100; receive read clears
// - tx empty 010; cleared by ident read, write
// - modem input change reports code 000, lowest
// - reading modem status clears modem interrupt
// - ident register at 3FAh or 2FAh
// - port enable low ignores whole address range
// - slot select high means first slot
// - force inputs make dcd cts dsr true
// - eight addresses from 03F8h or 02F8h
`default_nettype none

module sid_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata_ff,
  output logic             io_rdata_valid_ff,
  output logic             irq_ff,
  input  wire logic        port_enable_sw,
  input  wire logic        primary_slot_sw,
  input  wire logic        carrier_force_jumper,
  input  wire logic        clear_to_send_force_jumper,
  input  wire logic        set_ready_force_jumper,
  input  wire logic        line_cts,
  input  wire logic        line_dsr,
  input  wire logic        line_ri,
  input  wire logic        line_dcd,
  input  wire logic [3:0]  line_err_evt,
  input  wire logic        rx_strobe,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        tx_holding_empty,
  output logic [7:0]       tx_byte_ff,
  output logic             tx_load_ff,
  output logic [15:0]      divisor_ff,
  output logic [7:0]       line_ctrl_ff,
  output logic [7:0]       modem_ctrl_ff
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic port_hit(input logic [15:0] addr, input logic en,
                                    input logic primary);
    logic [15:0] base;
    base     = primary ? sid_pkg::BASE_PRIMARY : sid_pkg::BASE_SECONDARY;
    port_hit = en && (addr[15:3] == base[15:3]);
  endfunction

  function automatic logic [2:0] prio_code(input logic ls, input logic rx,
                                           input logic tx, input logic ms);
    if (ls) begin
      prio_code = sid_pkg::CODE_LS;
    end else if (rx) begin
      prio_code = sid_pkg::CODE_RX;
    end else if (tx) begin
      prio_code = sid_pkg::CODE_TX;
    end else if (ms) begin
      prio_code = sid_pkg::CODE_MS;
    end else begin
      prio_code = sid_pkg::CODE_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic       rd_hit;
  logic       wr_hit;
  logic [2:0] offs;
  logic       div_access;
  logic       rd_rbr;
  logic       rd_lsr;
  logic       rd_msr;
  logic       rd_iir;
  logic       wr_thr;
  logic [3:0] modem_eff;
  logic [3:0] modem_prev_ff;
  logic [3:0] modem_delta;
  logic [3:0] msr_flags;
  logic [3:0] ls_flags;
  logic       rx_pend;
  logic       tx_pend;
  logic       txe_prev_ff;
  logic       txe_rise;
  logic       tx_clr;
  logic [7:0] ier_ff;
  logic       ls_src;
  logic       rx_src;
  logic       tx_src;
  logic       ms_src;
  logic [2:0] iir_code;
  logic [7:0] nxt_rdata;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign rd_hit = io_rd && port_hit(io_addr, port_enable_sw, primary_slot_sw);
  assign wr_hit = io_wr && port_hit(io_addr, port_enable_sw, primary_slot_sw);
  assign offs   = io_addr[2:0];
  assign div_access = line_ctrl_ff[sid_pkg::DIV_ACCESS_BIT];
  assign rd_rbr = rd_hit && (offs == sid_pkg::OFF_DATA) && !div_access;
  assign rd_lsr = rd_hit && (offs == sid_pkg::OFF_LSR);
  assign rd_msr = rd_hit && (offs == sid_pkg::OFF_MSR);
  assign rd_iir = rd_hit && (offs == sid_pkg::OFF_IIR);
  assign wr_thr = wr_hit && (offs == sid_pkg::OFF_DATA) && !div_access;

  // ----------------------------------------------------------------
  // modem inputs with force jumpers
  // ----------------------------------------------------------------
  always_comb begin
    modem_eff                   = '0;
    modem_eff[sid_pkg::MDM_CTS] = line_cts | clear_to_send_force_jumper;
    modem_eff[sid_pkg::MDM_DSR] = line_dsr | set_ready_force_jumper;
    modem_eff[sid_pkg::MDM_RI]  = line_ri;
    modem_eff[sid_pkg::MDM_DCD] = line_dcd | carrier_force_jumper;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modem_prev_ff <= '0;
    end else begin
      modem_prev_ff <= modem_eff;
    end
  end

  assign modem_delta = modem_eff ^ modem_prev_ff;

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  sid_flags #(.W(4)) u_ls_flags (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_in   (line_err_evt),
    .clr_in   (rd_lsr),
    .flags_ff (ls_flags)
  );

  sid_flags #(.W(1)) u_rx_flag (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_in   (rx_strobe),
    .clr_in   (rd_rbr),
    .flags_ff (rx_pend)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txe_prev_ff <= 1'b1;
    end else begin
      txe_prev_ff <= tx_holding_empty;
    end
  end

  assign txe_rise = tx_holding_empty && !txe_prev_ff;
  assign tx_clr   = wr_thr || (rd_iir && (iir_code == sid_pkg::CODE_TX));

  sid_flags #(.W(1)) u_tx_flag (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_in   (txe_rise),
    .clr_in   (tx_clr),
    .flags_ff (tx_pend)
  );

  sid_flags #(.W(4)) u_ms_flags (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_in   (modem_delta),
    .clr_in   (rd_msr),
    .flags_ff (msr_flags)
  );

  // ----------------------------------------------------------------
  // prioritized identification
  // ----------------------------------------------------------------
  assign ls_src   = (|ls_flags) && ier_ff[sid_pkg::IER_LS];
  assign rx_src   = rx_pend && ier_ff[sid_pkg::IER_RX];
  assign tx_src   = tx_pend && ier_ff[sid_pkg::IER_TX];
  assign ms_src   = (|msr_flags) && ier_ff[sid_pkg::IER_MS];
  assign iir_code = prio_code(ls_src, rx_src, tx_src, ms_src);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (iir_code != sid_pkg::CODE_NONE);
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ier_ff        <= sid_pkg::RST_IER;
      line_ctrl_ff  <= sid_pkg::RST_LCR;
      modem_ctrl_ff <= sid_pkg::RST_MCR;
      divisor_ff    <= sid_pkg::RST_DIV;
    end else if (wr_hit) begin
      case (offs)
        sid_pkg::OFF_DATA: begin
          if (div_access) begin
            divisor_ff[7:0] <= io_wdata;
          end
        end
        sid_pkg::OFF_IER: begin
          if (div_access) begin
            divisor_ff[15:8] <= io_wdata;
          end else begin
            ier_ff <= {4'h0, io_wdata[3:0]};
          end
        end
        sid_pkg::OFF_LCR: line_ctrl_ff  <= io_wdata;
        sid_pkg::OFF_MCR: modem_ctrl_ff <= io_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_byte_ff <= 8'h00;
      tx_load_ff <= 1'b0;
    end else begin
      tx_load_ff <= wr_thr;
      if (wr_thr) begin
        tx_byte_ff <= io_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    case (offs)
      sid_pkg::OFF_DATA: nxt_rdata = div_access ? divisor_ff[7:0] : rx_byte;
      sid_pkg::OFF_IER:  nxt_rdata = div_access ? divisor_ff[15:8] : ier_ff;
      sid_pkg::OFF_IIR:  nxt_rdata = {5'h00, iir_code};
      sid_pkg::OFF_LCR:  nxt_rdata = line_ctrl_ff;
      sid_pkg::OFF_MCR:  nxt_rdata = modem_ctrl_ff;
      sid_pkg::OFF_LSR: begin
        nxt_rdata[sid_pkg::LSR_READY]                    = rx_pend;
        nxt_rdata[sid_pkg::LSR_ERR_LO+3:sid_pkg::LSR_ERR_LO] = ls_flags;
        nxt_rdata[sid_pkg::LSR_TXE]                      = tx_holding_empty;
      end
      sid_pkg::OFF_MSR:  nxt_rdata = {modem_eff, msr_flags};
      default:           nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_rdata_ff       <= 8'h00;
      io_rdata_valid_ff <= 1'b0;
    end else begin
      io_rdata_valid_ff <= rd_hit;
      if (rd_hit) begin
        io_rdata_ff <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ls_top;
    ls_src |-> iir_code == sid_pkg::CODE_LS;
  endproperty
  a_ls_top: assert property (p_ls_top) else $error("line status not top");

  property p_ls_clear;
    (rd_lsr && !(|line_err_evt)) |=> (ls_flags == 4'h0);
  endproperty
  a_ls_clear: assert property (p_ls_clear) else $error("lsr read kept flags");

  property p_rx_clear;
    (rd_rbr && !rx_strobe) |=> !rx_pend;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rbr read kept data flag");

  property p_tx_clear;
    (tx_clr && !txe_rise) |=> !tx_pend;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx empty not cleared");

  property p_ms_set;
    (|modem_delta) |=> (|msr_flags) && ((iir_code == sid_pkg::CODE_MS) ||
                       !ier_ff[sid_pkg::IER_MS] || ls_src || rx_src || tx_src);
  endproperty
  a_ms_set: assert property (p_ms_set) else $error("modem change lost");

  property p_ms_clear;
    (rd_msr && !(|modem_delta)) |=> (msr_flags == 4'h0);
  endproperty
  a_ms_clear: assert property (p_ms_clear) else $error("msr read kept flags");

  property p_iir_read;
    (io_rd && port_enable_sw && io_addr == (primary_slot_sw ? sid_pkg::IIR_ADDR_PRIMARY
                                            : sid_pkg::IIR_ADDR_SECOND))
      |=> io_rdata_valid_ff && (io_rdata_ff == {5'h00, $past(iir_code)});
  endproperty
  a_iir_read: assert property (p_iir_read) else $error("ident read wrong");

  property p_disabled;
    !port_enable_sw |=> !io_rdata_valid_ff && $stable(line_ctrl_ff) && $stable(ier_ff);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port answered");

  property p_outside;
    (io_rd && (io_addr[15:3] != (primary_slot_sw ? sid_pkg::BASE_PRIMARY[15:3]
                                 : sid_pkg::BASE_SECONDARY[15:3]))) |=> !io_rdata_valid_ff;
  endproperty
  a_outside: assert property (p_outside) else $error("outside range answered");

  property p_force;
    (!carrier_force_jumper || modem_eff[sid_pkg::MDM_DCD]) &&
      (!clear_to_send_force_jumper || modem_eff[sid_pkg::MDM_CTS]) &&
      (!set_ready_force_jumper || modem_eff[sid_pkg::MDM_DSR]);
  endproperty
  a_force: assert property (p_force) else $error("forced input not true");

  property p_rx_second;
    (rx_src && !ls_src) |-> iir_code == sid_pkg::CODE_RX;
  endproperty
  a_rx_second: assert property (p_rx_second) else $error("rx not second");

  property p_tx_third;
    (tx_src && !ls_src && !rx_src) |-> iir_code == sid_pkg::CODE_TX;
  endproperty
  a_tx_third: assert property (p_tx_third) else $error("tx not third");

  property p_irq;
    (iir_code == sid_pkg::CODE_NONE) |=> !irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("request with nothing pending");

endmodule

`default_nettype wire

// >>> common/sid_pkg.sv
// constants for the serial port interrupt identification block
// assumes an 8-bit host i/o bus with 16-bit addresses
`default_nettype none

package sid_pkg;

  // ----------------------------------------------------------------
  // address slots
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_PRIMARY     = 16'h03F8;
  localparam logic [15:0] BASE_SECONDARY   = 16'h02F8;
  localparam logic [15:0] IIR_ADDR_PRIMARY = 16'h03FA;
  localparam logic [15:0] IIR_ADDR_SECOND  = 16'h02FA;

  // ----------------------------------------------------------------
  // register offsets within the eight-address window
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER  = 3'h1;
  localparam logic [2:0] OFF_IIR  = 3'h2;
  localparam logic [2:0] OFF_LCR  = 3'h3;
  localparam logic [2:0] OFF_MCR  = 3'h4;
  localparam logic [2:0] OFF_LSR  = 3'h5;
  localparam logic [2:0] OFF_MSR  = 3'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DIV_ACCESS_BIT = 7;
  localparam int IER_RX     = 0;
  localparam int IER_TX     = 1;
  localparam int IER_LS     = 2;
  localparam int IER_MS     = 3;
  localparam int MDM_CTS    = 0;
  localparam int MDM_DSR    = 1;
  localparam int MDM_RI     = 2;
  localparam int MDM_DCD    = 3;
  localparam int LSR_READY  = 0;
  localparam int LSR_ERR_LO = 1;
  localparam int LSR_TXE    = 5;

  // ----------------------------------------------------------------
  // identification codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_LS   = 3'h6;
  localparam logic [2:0] CODE_RX   = 3'h4;
  localparam logic [2:0] CODE_TX   = 3'h2;
  localparam logic [2:0] CODE_MS   = 3'h0;
  localparam logic [2:0] CODE_NONE = 3'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_IER = 8'h00;
  localparam logic [7:0]  RST_LCR = 8'h00;
  localparam logic [7:0]  RST_MCR = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;

endpackage

`default_nettype wire

// >>> design/sid_flags.sv
// sticky event flags, set by hardware, cleared by one strobe
// assumes set pulses and clear strobe are synchronous to clk
`default_nettype none

module sid_flags #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] set_in,
  input  wire logic         clr_in,
  output logic [W-1:0]      flags_ff
);

  // ----------------------------------------------------------------
  // flags: a set in the clearing cycle survives
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= (flags_ff & ~{W{clr_in}}) | set_in;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/sid_peer_model.sv
// rs-232 peripheral stand-in: modem lines, receive and line error events
// assumes callers enter its tasks from a process synchronous to clk
`default_nettype none

module sid_peer_model (
  input  wire logic       clk,
  output var  logic       line_cts,
  output var  logic       line_dsr,
  output var  logic       line_ri,
  output var  logic       line_dcd,
  output var  logic [3:0] line_err_evt,
  output var  logic       rx_strobe,
  output var  logic [7:0] rx_byte,
  output var  logic       tx_holding_empty
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {line_dcd, line_ri, line_dsr, line_cts} = 4'h0;
    line_err_evt     = 4'h0;
    rx_strobe        = 1'b0;
    rx_byte          = 8'h00;
    tx_holding_empty = 1'b0;
  end

  // value order {dcd, ri, dsr, cts}
  task automatic set_modem(input logic [3:0] v);
    @(posedge clk);
    {line_dcd, line_ri, line_dsr, line_cts} <= v;
  endtask

  task automatic tx_empty(input logic v);
    @(posedge clk);
    tx_holding_empty <= v;
  endtask

  // byte held after the strobe until the next one
  task automatic send_byte(input logic [7:0] d);
    @(posedge clk);
    rx_byte   <= d;
    rx_strobe <= 1'b1;
    @(posedge clk);
    rx_strobe <= 1'b0;
  endtask

  task automatic line_error(input int i);
    @(posedge clk);
    line_err_evt <= 4'h1 << i;
    @(posedge clk);
    line_err_evt <= 4'h0;
  endtask
endmodule

`default_nettype wire

// >>> testbench/tb_serial_port_interrupt_ident.sv
// self-checking bench for the interrupt identification front end
// assumes sid_pkg, sid_top and sid_peer_model are compiled first
`default_nettype none

module tb_serial_port_interrupt_ident;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        sys_rst;
  logic [15:0] io_addr;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata_ff;
  logic        io_rdata_valid_ff;
  logic        irq_ff;
  logic        en_sw;
  logic        pri_sw;
  logic        dcd_f;
  logic        cts_f;
  logic        dsr_f;
  logic        cts;
  logic        dsr;
  logic        ri;
  logic        dcd;
  logic [3:0]  err_evt;
  logic        rx_stb;
  logic [7:0]  rx_b;
  logic        txe;
  logic [7:0]  tx_byte_ff;
  logic        tx_load_ff;
  logic [15:0] divisor_ff;
  logic [7:0]  line_ctrl_ff;
  logic [7:0]  modem_ctrl_ff;
  logic [15:0] b;
  logic [15:0] a;
  logic [7:0]  r;
  logic [7:0]  h;
  int          n_errors;
  int          n_tests;
  integer      seed;

  sid_top uut (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .io_rdata_valid_ff(io_rdata_valid_ff),
    .irq_ff(irq_ff), .port_enable_sw(en_sw), .primary_slot_sw(pri_sw),
    .carrier_force_jumper(dcd_f), .clear_to_send_force_jumper(cts_f),
    .set_ready_force_jumper(dsr_f), .line_cts(cts), .line_dsr(dsr), .line_ri(ri),
    .line_dcd(dcd), .line_err_evt(err_evt), .rx_strobe(rx_stb), .rx_byte(rx_b),
    .tx_holding_empty(txe), .tx_byte_ff(tx_byte_ff), .tx_load_ff(tx_load_ff),
    .divisor_ff(divisor_ff), .line_ctrl_ff(line_ctrl_ff), .modem_ctrl_ff(modem_ctrl_ff)
  );

  sid_peer_model peer (
    .clk(clk), .line_cts(cts), .line_dsr(dsr), .line_ri(ri), .line_dcd(dcd),
    .line_err_evt(err_evt), .rx_strobe(rx_stb), .rx_byte(rx_b), .tx_holding_empty(txe)
  );

  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [7:0] msr_exp(input logic [3:0] chg, input logic [3:0] cur);
    return {cur, chg};
  endfunction

  function automatic logic [7:0] lsr_exp(input int i);
    return 8'h20 | (8'h02 << i);
  endfunction

  // current modem bits {dcd, ri, dsr, cts} with idle lines and force {dcd, cts, dsr}
  function automatic logic [3:0] frc_exp(input logic [2:0] f);
    return {f[2], 1'b0, f[0], f[1]};
  endfunction

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask

  // ----------------------------------------------------------------
  // host bus cycles
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] off, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= {b[15:3], off};
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask

  task automatic acc(input logic [15:0] ad);
    @(posedge clk);
    io_addr <= ad;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
  endtask

  task automatic rdm(input logic [2:0] off, input logic [7:0] m, input logic [7:0] e);
    acc({b[15:3], off});
    chk({7'h00, io_rdata_valid_ff}, 8'h01);
    chk(io_rdata_ff & m, e);
  endtask

  task automatic rd(input logic [2:0] off, input logic [7:0] e);
    rdm(off, 8'hFF, e);
  endtask

  task automatic rd_none(input logic [15:0] ad);
    logic [7:0] old;
    old = io_rdata_ff;
    acc(ad);
    chk({7'h00, io_rdata_valid_ff}, 8'h00);
    chk(io_rdata_ff, old);
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    io_addr = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    {en_sw, pri_sw, dcd_f, cts_f, dsr_f} = 5'h18;
    n_errors = 0;
    n_tests = 0;
    seed = 32'hB87D;
    b = sid_pkg::BASE_PRIMARY;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(sid_pkg::OFF_IIR, 8'h01);
    chk({7'h00, irq_ff}, 8'h00);
    wr(sid_pkg::OFF_IER, 8'h0F);
    rd(sid_pkg::OFF_IER, 8'h0F);
    peer.set_modem(4'h1);
    idle(3);
    chk({7'h00, irq_ff}, 8'h01);
    rd(sid_pkg::OFF_IIR, 8'h00);
    rd(sid_pkg::OFF_MSR, msr_exp(4'h1, 4'h1));
    rd(sid_pkg::OFF_IIR, 8'h01);
    peer.set_modem(4'h5);
    idle(3);
    rd(sid_pkg::OFF_MSR, msr_exp(4'h4, 4'h5));
    peer.tx_empty(1'b1);
    idle(3);
    rd(sid_pkg::OFF_IIR, 8'h02);
    rd(sid_pkg::OFF_IIR, 8'h01);
    peer.tx_empty(1'b0);
    peer.tx_empty(1'b1);
    idle(3);
    chk({7'h00, irq_ff}, 8'h01);
    wr(sid_pkg::OFF_DATA, 8'h5A);
    chk({7'h00, tx_load_ff}, 8'h01);
    chk(tx_byte_ff, 8'h5A);
    rd(sid_pkg::OFF_IIR, 8'h01);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      peer.send_byte(r);
      idle(2);
      rd(sid_pkg::OFF_IIR, 8'h04);
      rd(sid_pkg::OFF_DATA, r);
      rd(sid_pkg::OFF_IIR, 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      peer.line_error(i);
      idle(2);
      rd(sid_pkg::OFF_IIR, 8'h06);
      rdm(sid_pkg::OFF_LSR, 8'h3F, lsr_exp(i));
      rd(sid_pkg::OFF_IIR, 8'h01);
    end
    peer.set_modem(4'h8);
    peer.tx_empty(1'b0);
    peer.tx_empty(1'b1);
    peer.send_byte(8'hC3);
    peer.line_error(2);
    idle(2);
    rd(sid_pkg::OFF_IIR, 8'h06);
    rdm(sid_pkg::OFF_LSR, 8'h3F, lsr_exp(2) | 8'h01);
    rd(sid_pkg::OFF_IIR, 8'h04);
    rd(sid_pkg::OFF_DATA, 8'hC3);
    rd(sid_pkg::OFF_IIR, 8'h02);
    rd(sid_pkg::OFF_IIR, 8'h00);
    rd(sid_pkg::OFF_MSR, msr_exp(4'hD, 4'h8));
    idle(2);
    chk({7'h00, irq_ff}, 8'h00);
    peer.set_modem(4'h0);
    idle(3);
    rd(sid_pkg::OFF_MSR, msr_exp(4'h8, 4'h0));
    @(posedge clk);
    {dcd_f, cts_f, dsr_f} <= 3'b111;
    idle(3);
    rd(sid_pkg::OFF_MSR, msr_exp(4'hB, 4'hB));
    @(posedge clk);
    {dcd_f, cts_f, dsr_f} <= 3'b000;
    idle(3);
    rd(sid_pkg::OFF_MSR, msr_exp(4'hB, 4'h0));
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      @(posedge clk);
      {dcd_f, cts_f, dsr_f} <= r[2:0];
      idle(3);
      rdm(sid_pkg::OFF_MSR, 8'hF0, msr_exp(4'h0, frc_exp(r[2:0])));
    end
    @(posedge clk);
    {dcd_f, cts_f, dsr_f} <= 3'b000;
    idle(3);
    rdm(sid_pkg::OFF_MSR, 8'hF0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      wr(sid_pkg::OFF_MCR, r);
      chk(modem_ctrl_ff, r);
      rd(sid_pkg::OFF_MCR, r);
    end
    r = $random(seed);
    h = $random(seed);
    wr(sid_pkg::OFF_LCR, 8'h80);
    wr(sid_pkg::OFF_DATA, r);
    wr(sid_pkg::OFF_IER, h);
    chk(divisor_ff[7:0], r);
    chk(divisor_ff[15:8], h);
    rd(sid_pkg::OFF_DATA, r);
    rd(sid_pkg::OFF_IER, h);
    rd(sid_pkg::OFF_LCR, 8'h80);
    wr(sid_pkg::OFF_LCR, 8'h00);
    chk(line_ctrl_ff, 8'h00);
    rd(sid_pkg::OFF_IER, 8'h0F);
    rd(3'h7, 8'h00);
    rd_none(16'h03F7);
    rd_none(16'h0400);
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      a[9] = 1'b0;
      rd_none(a);
    end
    @(posedge clk);
    b = sid_pkg::BASE_SECONDARY;
    pri_sw <= (b == sid_pkg::BASE_PRIMARY);
    rd(sid_pkg::OFF_IIR, 8'h01);
    rd_none(sid_pkg::IIR_ADDR_PRIMARY);
    wr(sid_pkg::OFF_MCR, 8'h3C);
    rd(sid_pkg::OFF_MCR, 8'h3C);
    rd(3'h7, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      @(posedge clk);
      en_sw <= r[0];
      if (r[0]) begin
        rd(sid_pkg::OFF_MCR, 8'h3C);
      end else begin
        rd_none(sid_pkg::IIR_ADDR_SECOND);
      end
    end
    @(posedge clk);
    en_sw <= 1'b0;
    rd_none(sid_pkg::IIR_ADDR_SECOND);
    wr(sid_pkg::OFF_MCR, 8'hC3);
    chk(modem_ctrl_ff, 8'h3C);
    tally_and_finish;
  end
endmodule

`default_nettype wire
